// ===== design/lics_defs.vh
// register map, field positions, reset values and code tables of the line control block
`ifndef LICS_DEFS_VH
`define LICS_DEFS_VH

// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define LICS_IDX_RX_LEVEL_INFO 8'h11
`define LICS_IDX_LINE_STATUS 8'h14
`define LICS_IDX_LINE_IRQ_MASK 8'h15
`define LICS_IDX_LINE_IRQ_PEND 8'h16
`define LICS_IDX_LINE_CTRL_TWO 8'h31
`define LICS_IDX_CMI_MON_CTRL 8'h32
`define LICS_IDX_TERM_PRESCALE 8'h33

// ----------------------------------------------------------------
// writable bit masks (unused positions read as zero)
// ----------------------------------------------------------------
`define LICS_MASK_LINE_CTRL_TWO 8'h88
`define LICS_MASK_CMI_MON_CTRL 8'hD8
`define LICS_MASK_TERM_PRESCALE 8'hFF
`define LICS_MASK_LINE_IRQ_MASK 8'h16

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LICS_RST_LINE_CTRL_TWO 8'h00
`define LICS_RST_CMI_MON_CTRL 8'h00
`define LICS_RST_TERM_PRESCALE 8'h00
`define LICS_RST_LINE_IRQ_MASK 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LICS_BIT_JA_SEL_T1 3
`define LICS_BIT_JA_SEL_E1 7
`define LICS_BIT_MON_GAIN_LO 3
`define LICS_BIT_MON_GAIN_HI 4
`define LICS_BIT_CMI_INV 6
`define LICS_BIT_CMI_EN 7
`define LICS_BIT_RX_TERM_LO 0
`define LICS_BIT_RX_TERM_HI 2
`define LICS_BIT_TX_TERM_LO 3
`define LICS_BIT_TX_TERM_HI 5
`define LICS_BIT_PRESCALE_LO 6
`define LICS_BIT_PRESCALE_HI 7
`define LICS_BIT_OPEN_FLAG 1
`define LICS_BIT_LIMIT_FLAG 2
`define LICS_BIT_JA_EVENT 4

// ----------------------------------------------------------------
// code tables
// ----------------------------------------------------------------
`define LICS_GAIN_BOOST_0 6'h00
`define LICS_GAIN_BOOST_1 6'h14
`define LICS_GAIN_BOOST_2 6'h1A
`define LICS_GAIN_BOOST_3 6'h20
`define LICS_TERM_OFF 3'h0
`define LICS_TERM_75 3'h1
`define LICS_TERM_100 3'h2
`define LICS_TERM_120 3'h3
`define LICS_TERM_110 3'h4

// ----------------------------------------------------------------
// jitter fifo margin, in bits
// ----------------------------------------------------------------
`define LICS_JA_MARGIN 4

`endif

// ===== design/lics_sync.v
// two-stage synchroniser for a group of level inputs
`timescale 1ns/1ns
module lics_sync #(
  parameter WIDTH = 1
) (
  input wire ref_clk, // system clock
  input wire resetn, // synchronous reset, active low
  input wire [WIDTH-1:0] async_in, // level from outside the clock domain
  output reg [WIDTH-1:0] sync_out // synchronised level
);

  reg [WIDTH-1:0] meta;

  always @(posedge ref_clk) begin
    if (!resetn) begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// ===== design/lics_line_ctrl.v
// line interface control and status registers behind an avalon-mm slave
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ns
`include "lics_defs.vh"
module lics_line_ctrl #(
  parameter JA_FIFO_DEPTH = 128,
  parameter JA_FILL_WIDTH = 8
) (
  input wire ref_clk, // 100 mhz system clock
  input wire resetn, // synchronous reset, active low
  input wire [9:0] avs_address, // byte address
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire [31:0] avs_writedata, // write data
  input wire [3:0] avs_byteenable, // byte enables
  output reg [31:0] avs_readdata, // read data
  output reg avs_waitrequest, // low for the one answering cycle
  input wire tx_open_detect, // analog open-circuit detector, async
  input wire tx_current_trip, // analog current limiter active, async
  input wire [3:0] rx_level_meas, // analog receive level band, async
  input wire [JA_FILL_WIDTH-1:0] ja_fill, // jitter fifo fill in bits
  input wire tx_mode_6312k, // transmitter in 6312 khz mode
  input wire tx_mode_64k, // transmitter in 64 khz mode
  output reg [1:0] monitor_gain, // monitor gain code
  output reg [5:0] monitor_boost_db, // linear gain boost in db
  output reg cmi_enable, // cmi line coding on
  output reg cmi_polarity_invert, // cmi polarity inverted
  output reg [2:0] rx_term_sel, // receive termination code
  output reg rx_term_enable, // receive termination active
  output reg [2:0] tx_term_sel, // transmit termination code
  output reg tx_term_enable, // transmit termination active
  output reg [1:0] master_prescale, // master clock prescaler
  output reg ja_clk_sel_t1_pll, // 2.048 to 1.544 pll enabled
  output reg ja_clk_sel_e1_pll, // 12.8 to 2.048 pll enabled
  output reg line_irq // interrupt request, active high
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  reg [7:0] line_ctrl_two;
  reg [7:0] cmi_monitor_ctrl;
  reg [7:0] termination_prescale_ctrl;
  reg [7:0] line_interrupt_mask;
  reg jitter_fifo_limit_event;
  reg [2:0] irq_pending;
  reg open_prev;
  reg limit_prev;
  reg ja_near_prev;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  wire [5:0] sync_bus;
  wire tx_open_sync;
  wire tx_trip_sync;
  wire [3:0] rx_level_sync;

  lics_sync #(
    .WIDTH(6)
  ) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in({rx_level_meas, tx_current_trip, tx_open_detect}),
    .sync_out(sync_bus)
  );

  assign tx_open_sync = sync_bus[0];
  assign tx_trip_sync = sync_bus[1];
  assign rx_level_sync = sync_bus[5:2];

  // ----------------------------------------------------------------
  // live status qualification
  // ----------------------------------------------------------------
  wire tx_open_circuit_flag;
  wire tx_current_limit_flag;
  wire ja_near_limit;
  wire [JA_FILL_WIDTH:0] fill_ext;

  // detector ignored in 6312 khz mode
  assign tx_open_circuit_flag = tx_open_sync & ~tx_mode_6312k;
  // trip reported regardless of limiter enable, except unsupported modes
  assign tx_current_limit_flag = tx_trip_sync & ~cmi_enable & ~tx_mode_64k
    & ~tx_mode_6312k;

  wire ja_near_top;
  wire ja_near_bottom;

  // near either end of the usable fifo span
  assign fill_ext = {1'b0, ja_fill};
  assign ja_near_top = (fill_ext + `LICS_JA_MARGIN) >= JA_FIFO_DEPTH;
  assign ja_near_bottom = fill_ext <= `LICS_JA_MARGIN;
  assign ja_near_limit = ja_near_top | ja_near_bottom;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire [7:0] reg_index;
  wire access;
  wire wr_acc;
  wire rd_acc;
  wire wr_lane0;
  wire rd_status;
  reg [7:0] rd_value;
  reg rd_hit;

  assign reg_index = avs_address[9:2];
  assign access = (avs_read | avs_write) & avs_waitrequest;
  assign wr_acc = access & avs_write;
  assign rd_acc = access & avs_read & ~avs_write;
  assign wr_lane0 = wr_acc & avs_byteenable[0];
  assign rd_status = rd_acc && (reg_index == `LICS_IDX_LINE_STATUS);

  always @* begin
    rd_value = 8'h00;
    rd_hit = 1'b1;
    case (reg_index)
      `LICS_IDX_RX_LEVEL_INFO: begin
        rd_value = {4'h0, rx_level_sync};
      end
      `LICS_IDX_LINE_STATUS: begin
        rd_value[`LICS_BIT_OPEN_FLAG] = tx_open_circuit_flag;
        rd_value[`LICS_BIT_LIMIT_FLAG] = tx_current_limit_flag;
        rd_value[`LICS_BIT_JA_EVENT] = jitter_fifo_limit_event;
      end
      `LICS_IDX_LINE_IRQ_MASK: begin
        rd_value = line_interrupt_mask;
      end
      `LICS_IDX_LINE_IRQ_PEND: begin
        rd_value[`LICS_BIT_OPEN_FLAG] = irq_pending[0];
        rd_value[`LICS_BIT_LIMIT_FLAG] = irq_pending[1];
        rd_value[`LICS_BIT_JA_EVENT] = irq_pending[2];
      end
      `LICS_IDX_LINE_CTRL_TWO: begin
        rd_value = line_ctrl_two;
      end
      `LICS_IDX_CMI_MON_CTRL: begin
        rd_value = cmi_monitor_ctrl;
      end
      `LICS_IDX_TERM_PRESCALE: begin
        rd_value = termination_prescale_ctrl;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // avalon handshake, one wait state per access
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      if (access) begin
        avs_waitrequest <= 1'b0;
        if (rd_acc && rd_hit) begin
          avs_readdata <= {24'h00_0000, rd_value};
        end else begin
          avs_readdata <= 32'h0000_0000;
        end
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!resetn) begin
      line_ctrl_two <= `LICS_RST_LINE_CTRL_TWO;
      cmi_monitor_ctrl <= `LICS_RST_CMI_MON_CTRL;
      termination_prescale_ctrl <= `LICS_RST_TERM_PRESCALE;
      line_interrupt_mask <= `LICS_RST_LINE_IRQ_MASK;
    end else if (wr_lane0) begin
      case (reg_index)
        `LICS_IDX_LINE_CTRL_TWO: begin
          line_ctrl_two <= avs_writedata[7:0] & `LICS_MASK_LINE_CTRL_TWO;
        end
        `LICS_IDX_CMI_MON_CTRL: begin
          cmi_monitor_ctrl <= avs_writedata[7:0] & `LICS_MASK_CMI_MON_CTRL;
        end
        `LICS_IDX_TERM_PRESCALE: begin
          termination_prescale_ctrl <= avs_writedata[7:0] & `LICS_MASK_TERM_PRESCALE;
        end
        `LICS_IDX_LINE_IRQ_MASK: begin
          // unused positions dropped, software keeps them zero
          line_interrupt_mask <= avs_writedata[7:0] & `LICS_MASK_LINE_IRQ_MASK;
        end
        default: begin
          line_ctrl_two <= line_ctrl_two;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status event and interrupt pending bits
  // ----------------------------------------------------------------
  wire open_edge;
  wire limit_edge;
  wire ja_rise;
  wire [2:0] flag_change;
  wire [2:0] flag_mask;
  wire [2:0] next_pending_set;

  assign open_edge = open_prev ^ tx_open_circuit_flag;
  assign limit_edge = limit_prev ^ tx_current_limit_flag;
  assign ja_rise = ja_near_limit & ~ja_near_prev;
  assign flag_change = {ja_rise, limit_edge, open_edge};
  assign flag_mask = {line_interrupt_mask[`LICS_BIT_JA_EVENT],
    line_interrupt_mask[`LICS_BIT_LIMIT_FLAG], line_interrupt_mask[`LICS_BIT_OPEN_FLAG]};

  genvar ent;
  generate
    for (ent = 0; ent < 3; ent = ent + 1) begin : g_pend
      // mask gates setting only, not a bit already pending
      assign next_pending_set[ent] = flag_change[ent] & flag_mask[ent];
    end
  endgenerate

  always @(posedge ref_clk) begin
    if (!resetn) begin
      open_prev <= 1'b0;
      limit_prev <= 1'b0;
      ja_near_prev <= 1'b0;
      jitter_fifo_limit_event <= 1'b0;
      irq_pending <= 3'h0;
    end else begin
      open_prev <= tx_open_circuit_flag;
      limit_prev <= tx_current_limit_flag;
      ja_near_prev <= ja_near_limit;
      // new event wins over the clearing read
      if (ja_rise) begin
        jitter_fifo_limit_event <= 1'b1;
      end else if (rd_status) begin
        jitter_fifo_limit_event <= 1'b0;
      end
      if (rd_status) begin
        irq_pending <= next_pending_set;
      end else begin
        irq_pending <= irq_pending | next_pending_set;
      end
    end
  end

  // ----------------------------------------------------------------
  // decoded outputs
  // ----------------------------------------------------------------
  wire [2:0] rx_code;
  wire [2:0] tx_code;
  wire [1:0] gain_code;

  assign rx_code = termination_prescale_ctrl[`LICS_BIT_RX_TERM_HI:`LICS_BIT_RX_TERM_LO];
  assign tx_code = termination_prescale_ctrl[`LICS_BIT_TX_TERM_HI:`LICS_BIT_TX_TERM_LO];
  assign gain_code = {cmi_monitor_ctrl[`LICS_BIT_MON_GAIN_HI],
    cmi_monitor_ctrl[`LICS_BIT_MON_GAIN_LO]};

  // ----------------------------------------------------------------
  // termination decode, one slice per direction
  // ----------------------------------------------------------------
  wire [5:0] term_codes;
  wire [1:0] next_term_enable;

  assign term_codes = {tx_code, rx_code};

  genvar dir;
  generate
    for (dir = 0; dir < 2; dir = dir + 1) begin : g_term
      // codes above the last table entry leave the line open
      assign next_term_enable[dir] = (term_codes[3*dir +: 3] >= `LICS_TERM_75)
        && (term_codes[3*dir +: 3] <= `LICS_TERM_110);
    end
  endgenerate

  always @(posedge ref_clk) begin
    if (!resetn) begin
      monitor_gain <= 2'h0;
      monitor_boost_db <= `LICS_GAIN_BOOST_0;
      cmi_enable <= 1'b0;
      cmi_polarity_invert <= 1'b0;
      rx_term_sel <= `LICS_TERM_OFF;
      rx_term_enable <= 1'b0;
      tx_term_sel <= `LICS_TERM_OFF;
      tx_term_enable <= 1'b0;
      master_prescale <= 2'h0;
      ja_clk_sel_t1_pll <= 1'b0;
      ja_clk_sel_e1_pll <= 1'b0;
    end else begin
      monitor_gain <= gain_code;
      case (gain_code)
        2'h0: monitor_boost_db <= `LICS_GAIN_BOOST_0;
        2'h1: monitor_boost_db <= `LICS_GAIN_BOOST_1;
        2'h2: monitor_boost_db <= `LICS_GAIN_BOOST_2;
        default: monitor_boost_db <= `LICS_GAIN_BOOST_3;
      endcase
      cmi_enable <= cmi_monitor_ctrl[`LICS_BIT_CMI_EN];
      cmi_polarity_invert <= cmi_monitor_ctrl[`LICS_BIT_CMI_INV];
      rx_term_sel <= rx_code;
      rx_term_enable <= next_term_enable[0];
      tx_term_sel <= tx_code;
      tx_term_enable <= next_term_enable[1];
      // prescaler and selects as software set them for the master clock
      master_prescale <= termination_prescale_ctrl[`LICS_BIT_PRESCALE_HI:
        `LICS_BIT_PRESCALE_LO];
      ja_clk_sel_t1_pll <= line_ctrl_two[`LICS_BIT_JA_SEL_T1];
      ja_clk_sel_e1_pll <= line_ctrl_two[`LICS_BIT_JA_SEL_E1];
    end
  end

  // ----------------------------------------------------------------
  // interrupt output
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!resetn) begin
      line_irq <= 1'b0;
    end else begin
      line_irq <= |irq_pending;
    end
  end

endmodule

// ===== testbench/lics_line_ctrl_properties.sv
// assertion checker for the line control register block
`timescale 1ns/1ns
module lics_line_ctrl_props (
  input wire ref_clk, // clock
  input wire resetn, // reset, active low
  input wire [9:0] avs_address, // byte address
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire [31:0] avs_writedata, // write data
  input wire [3:0] avs_byteenable, // byte enables
  input wire [31:0] avs_readdata, // read data
  input wire avs_waitrequest, // wait
  input wire tx_mode_6312k, // 6312 khz mode
  input wire tx_mode_64k, // 64 khz mode
  input wire [1:0] monitor_gain, // gain code
  input wire [5:0] monitor_boost_db, // boost in db
  input wire cmi_enable, // cmi on
  input wire cmi_polarity_invert, // cmi inverted
  input wire [2:0] rx_term_sel, // rx code
  input wire rx_term_enable, // rx on
  input wire [2:0] tx_term_sel, // tx code
  input wire tx_term_enable, // tx on
  input wire [1:0] master_prescale // prescaler
);
  // ----
  // sequences and properties
  // ----
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_wr(idx);
    avs_write && avs_waitrequest && avs_byteenable[0] && avs_address[9:2] == idx;
  endsequence
  sequence s_rd(idx);
    avs_read && avs_waitrequest && avs_address[9:2] == idx;
  endsequence
  a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer not one cycle");
  a_cmi_gain_follow: assert property (s_wr(8'h32) |-> ##2 {cmi_enable, cmi_polarity_invert,
    monitor_gain} == {$past(avs_writedata[7:6], 2), $past(avs_writedata[4:3], 2)})
    else $error("cmi or gain output wrong");
  a_term_follow: assert property (s_wr(8'h33) |-> ##2 {master_prescale, tx_term_sel,
    rx_term_sel} == $past(avs_writedata[7:0], 2)) else $error("termination output wrong");
  a_boost_table: assert property ($stable(monitor_gain) |-> monitor_boost_db ==
    (monitor_gain == 2'h0 ? 6'h00 : monitor_gain == 2'h1 ? 6'h14 :
    monitor_gain == 2'h2 ? 6'h1A : 6'h20)) else $error("boost wrong");
  a_rx_term_on: assert property ($stable(rx_term_sel) |->
    rx_term_enable == (rx_term_sel inside {[3'h1:3'h4]})) else $error("rx term enable wrong");
  a_tx_term_on: assert property ($stable(tx_term_sel) |->
    tx_term_enable == (tx_term_sel inside {[3'h1:3'h4]})) else $error("tx term enable wrong");
  a_open_blocked: assert property (tx_mode_6312k [*4] ##0 s_rd(8'h14) |=>
    !avs_readdata[1]) else $error("open flag in 6312k mode");
  a_limit_blocked: assert property ((tx_mode_64k || tx_mode_6312k || cmi_enable) [*4]
    ##0 s_rd(8'h14) |=> !avs_readdata[2]) else $error("limit flag in blocked mode");
  a_unused_zero: assert property (avs_read && avs_waitrequest && (avs_address[9:2] == 8'h14
    || avs_address[9:2] == 8'h15) |=> (avs_readdata & 32'hFFFFFFE9) == 32'h0)
    else $error("unused status bits set");
endmodule

bind lics_line_ctrl lics_line_ctrl_props lics_line_ctrl_props_inst (.ref_clk, .resetn,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .tx_mode_6312k, .tx_mode_64k, .monitor_gain, .monitor_boost_db,
  .cmi_enable, .cmi_polarity_invert, .rx_term_sel, .rx_term_enable, .tx_term_sel,
  .tx_term_enable, .master_prescale);

// ===== testbench/tb_lics_line_ctrl.sv
// self-checking bench for the line control register block
`timescale 1ns/1ns
module tb_lics_line_ctrl;
  reg ref_clk = 1'b0;
  reg resetn = 1'b0;
  reg [9:0] avs_address = 10'h000;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg [3:0] avs_byteenable = 4'hF;
  reg tx_open_detect = 1'b0;
  reg tx_current_trip = 1'b0;
  reg [3:0] rx_level_meas = 4'h0;
  reg [7:0] ja_fill = 8'h3C;
  reg tx_mode_6312k = 1'b0;
  reg tx_mode_64k = 1'b0;
  wire [31:0] avs_readdata;
  wire [5:0] monitor_boost_db;
  wire [2:0] rx_term_sel, tx_term_sel;
  wire [1:0] monitor_gain, master_prescale;
  wire avs_waitrequest, cmi_enable, cmi_polarity_invert, rx_term_enable, tx_term_enable;
  wire ja_clk_sel_t1_pll, ja_clk_sel_e1_pll, line_irq;
  integer bad_count = 0;
  integer n_checks = 0;
  integer i;
  reg [7:0] mdl [0:255];
  reg [7:0] v;
  reg [31:0] rd;

  lics_line_ctrl lics_line_ctrl_inst (.ref_clk, .resetn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .tx_open_detect, .tx_current_trip, .rx_level_meas, .ja_fill, .tx_mode_6312k,
    .tx_mode_64k, .monitor_gain, .monitor_boost_db, .cmi_enable, .cmi_polarity_invert,
    .rx_term_sel, .rx_term_enable, .tx_term_sel, .tx_term_enable, .master_prescale,
    .ja_clk_sel_t1_pll, .ja_clk_sel_e1_pll, .line_irq);

  always #5 ref_clk = ~ref_clk;

  // ----
  // model and bus tasks
  // ----
  function [7:0] msk(input [7:0] idx);
    case (idx)
      8'h15: msk = 8'h16;
      8'h31: msk = 8'h88;
      8'h32: msk = 8'hD8;
      8'h33: msk = 8'hFF;
      default: msk = 8'h00;
    endcase
  endfunction
  function [5:0] boost(input [1:0] g);
    boost = g == 2'h0 ? 6'h00 : g == 2'h1 ? 6'h14 : g == 2'h2 ? 6'h1A : 6'h20;
  endfunction
  function te(input [2:0] c);
    te = c >= 3'h1 && c <= 3'h4;
  endfunction
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task ack;
    integer n;
    n = 0;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      n = n + 1;
      @(posedge ref_clk);
    end
    if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wr(input [7:0] idx, input [7:0] d, input [3:0] be);
    @(posedge ref_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= 1'b1;
    ack;
    if (be[0]) mdl[idx] = d & msk(idx);
  endtask
  task rdc(input [7:0] idx, input [7:0] exp);
    @(posedge ref_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= 1'b1;
    ack;
    chk("readdata", {24'h0, exp}, rd);
  endtask
  task outs;
    repeat (2) @(posedge ref_clk);
    chk("gain", {boost(mdl[8'h32][4:3]), mdl[8'h32][4:3]}, {monitor_boost_db, monitor_gain});
    chk("cmi", mdl[8'h32][7:6], {cmi_enable, cmi_polarity_invert});
    chk("rxterm", {te(mdl[8'h33][2:0]), mdl[8'h33][2:0]}, {rx_term_enable, rx_term_sel});
    chk("txterm", {te(mdl[8'h33][5:3]), mdl[8'h33][5:3]}, {tx_term_enable, tx_term_sel});
    chk("prescale", mdl[8'h33][7:6], master_prescale);
    chk("jasel", {mdl[8'h31][7], mdl[8'h31][3]}, {ja_clk_sel_e1_pll, ja_clk_sel_t1_pll});
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task irq_is(input e);
    repeat (6) @(posedge ref_clk);
    chk("line_irq", e, line_irq);
  endtask

  initial begin
    #300000;
    bad_count = bad_count + 1;
    close_out;
  end

  // ----
  // scenarios
  // ----
  initial begin
    i = $urandom(32'h544da3e7);
    for (i = 0; i < 256; i = i + 1) mdl[i] = 8'h00;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    rdc(8'h15, 8'h00);
    rdc(8'h33, 8'h00);
    outs;
    for (i = 0; i < 16; i = i + 1) begin
      v = $urandom;
      wr(8'h33, {v[7:6], i[2:0], ~i[2:0]}, 4'hF);
      wr(8'h32, {v[5:4], 1'b0, i[1:0], 3'h0}, 4'hF);
      wr(8'h31, {v[3] & ~|v[7:6], 3'h0, v[2], 3'h0}, 4'hF);
      rdc(8'h33, mdl[8'h33]);
      rdc(8'h32, mdl[8'h32]);
      rdc(8'h31, mdl[8'h31]);
      outs;
    end
    wr(8'h33, 8'hA5, 4'h0);
    rdc(8'h33, mdl[8'h33]);
    wr(8'h40, 8'hFF, 4'hF);
    rdc(8'h40, 8'h00);
    for (i = 0; i < 16; i = i + 1) begin
      @(posedge ref_clk);
      rx_level_meas <= i[3:0];
      repeat (4) @(posedge ref_clk);
      rdc(8'h11, {4'h0, i[3:0]});
    end
    wr(8'h32, 8'h00, 4'hF);
    wr(8'h15, 8'h02, 4'hF);
    tx_open_detect <= 1'b1;
    irq_is(1'b1);
    rdc(8'h16, 8'h02);
    rdc(8'h14, 8'h02);
    irq_is(1'b0);
    tx_open_detect <= 1'b0;
    irq_is(1'b1);
    rdc(8'h14, 8'h00);
    wr(8'h15, 8'h00, 4'hF);
    tx_current_trip <= 1'b1;
    irq_is(1'b0);
    rdc(8'h14, 8'h04);
    wr(8'h32, 8'h80, 4'hF);
    rdc(8'h14, 8'h00);
    wr(8'h32, 8'h00, 4'hF);
    tx_mode_64k <= 1'b1;
    irq_is(1'b0);
    rdc(8'h14, 8'h00);
    tx_current_trip <= 1'b0;
    tx_mode_64k <= 1'b0;
    tx_mode_6312k <= 1'b1;
    tx_open_detect <= 1'b1;
    irq_is(1'b0);
    rdc(8'h14, 8'h00);
    tx_mode_6312k <= 1'b0;
    tx_open_detect <= 1'b0;
    irq_is(1'b0);
    rdc(8'h14, 8'h00);
    wr(8'h15, 8'h10, 4'hF);
    ja_fill <= 8'd123;
    irq_is(1'b0);
    ja_fill <= 8'd124;
    irq_is(1'b1);
    rdc(8'h16, 8'h10);
    rdc(8'h14, 8'h10);
    rdc(8'h14, 8'h00);
    irq_is(1'b0);
    ja_fill <= 8'd60;
    wr(8'h15, 8'h00, 4'hF);
    ja_fill <= 8'd124;
    irq_is(1'b0);
    rdc(8'h14, 8'h10);
    ja_fill <= 8'h3C;
    irq_is(1'b0);
    ja_fill <= 8'h04;
    irq_is(1'b0);
    rdc(8'h14, 8'h10);
    close_out;
  end
endmodule
